/* File: inc/rbd_defines.svh */
// constants of the register bus datapath: widths, bit fields, store mask, addresses
`ifndef RBD_DEFINES_SVH
`define RBD_DEFINES_SVH

`define RBD_WIDTH        16
`define RBD_MSB          15
`define RBD_SIGN_BIT     15
`define RBD_ADDR_MSB     14
`define RBD_MOD_HI       14
`define RBD_MOD_LO       12
`define RBD_DST_WIDTH    5
`define RBD_DST_T        0
`define RBD_DST_P        1
`define RBD_DST_M        2
`define RBD_DST_A        3
`define RBD_DST_B        4
`define RBD_ZERO_WORD    16'h0000
`define RBD_ONE_WORD     16'h0001
`define RBD_TWO_WORD     16'h0002
`define RBD_DST_NONE     5'h00
`define RBD_RESET_WORD   16'h0000

`endif

/* File: inc/rbd_pkg.sv */
// types shared by the datapath and its arithmetic unit
package rbd_pkg;

	// sequencer commands
	typedef enum logic [3:0] {
		OP_MICRO, OP_FETCH, OP_READ, OP_WRITE, OP_ADVANCE, OP_SKIP,
		OP_JUMP, OP_CLEAR_E, OP_CLEAR_O, OP_HALT, OP_RUN
	} rbd_op_e;

	// operand bus sources
	typedef enum logic [2:0] {
		SRC_ZERO, SRC_T, SRC_P, SRC_M, SRC_A, SRC_B
	} rbd_src_e;

	// arithmetic unit functions
	typedef enum logic [3:0] {
		FN_PASS_R, FN_PASS_S, FN_ADD, FN_AND, FN_XOR, FN_OR, FN_CMP, FN_CMPL,
		FN_SHL, FN_SHR, FN_ROL, FN_ROR, FN_ROL_E, FN_ROR_E, FN_INC, FN_INC2
	} rbd_func_e;

	// boolean functions allowed only into the first accumulator
	function automatic logic rbd_is_logic(input rbd_func_e f);
		return (f == FN_AND) || (f == FN_XOR) || (f == FN_OR);
	endfunction : rbd_is_logic

endpackage : rbd_pkg

/* File: inc/rbd_alu_if.sv */
// operand, function and result buses between the datapath and its arithmetic unit
`timescale 1ns/10ps
interface rbd_alu_if;
	logic                [15:0] r_bus;
	logic                [15:0] s_bus;
	logic                [15:0] t_bus;
	rbd_pkg::rbd_func_e         func;
	logic                       e_in;
	logic                       carry;
	logic                       ovf;
	logic                       zero;

	modport dp (output r_bus, output s_bus, output func, output e_in,
		input t_bus, input carry, input ovf, input zero);
	modport alu (input r_bus, input s_bus, input func, input e_in,
		output t_bus, output carry, output ovf, output zero);
endinterface : rbd_alu_if

/* File: hdl/rbd_alu.sv */
// arithmetic unit: combines the left and right operand buses onto the result bus
`timescale 1ns/10ps
`include "rbd_defines.svh"
module rbd_alu (
	rbd_alu_if.alu bus
);
	wire logic [16:0] sum_add;
	wire logic [15:0] low_add;
	wire logic [16:0] sum_inc;
	wire logic [15:0] low_inc;
	wire logic [15:0] add_b;
	wire logic        use_add;
	wire logic        c14;
	wire logic        r_neg;
	wire logic        b_neg;
	logic      [15:0] res;
	logic             cout;

	// one adder serves add and both increments; the right operand is swapped in
	assign add_b   = (bus.func == rbd_pkg::FN_INC) ? `RBD_ONE_WORD :
		(bus.func == rbd_pkg::FN_INC2) ? `RBD_TWO_WORD : bus.s_bus;
	assign use_add = (bus.func == rbd_pkg::FN_ADD) || (bus.func == rbd_pkg::FN_INC) ||
		(bus.func == rbd_pkg::FN_INC2);
	assign sum_add = {1'b0, bus.r_bus} + {1'b0, add_b};
	assign low_add = {1'b0, bus.r_bus[14:0]} + {1'b0, add_b[14:0]};
	assign sum_inc = sum_add;
	assign low_inc = low_add;
	assign c14     = low_inc[15];                               // carry into the sign bit
	assign r_neg   = bus.r_bus[`RBD_SIGN_BIT];
	assign b_neg   = add_b[`RBD_SIGN_BIT];

	// function select; the carry output also carries the bit rotated out through extend
	always_comb
	begin
		res  = bus.r_bus;
		cout = 1'b0;
		case (bus.func)
			rbd_pkg::FN_PASS_R: res = bus.r_bus;
			rbd_pkg::FN_PASS_S: res = bus.s_bus;
			rbd_pkg::FN_ADD,
			rbd_pkg::FN_INC,
			rbd_pkg::FN_INC2:
			begin
				res  = sum_inc[15:0];
				cout = sum_inc[16];
			end
			rbd_pkg::FN_AND:    res = bus.r_bus & bus.s_bus;
			rbd_pkg::FN_XOR:    res = bus.r_bus ^ bus.s_bus;
			rbd_pkg::FN_OR:     res = bus.r_bus | bus.s_bus;
			rbd_pkg::FN_CMP:    res = bus.r_bus ^ bus.s_bus;      // zero when equal
			rbd_pkg::FN_CMPL:   res = ~bus.r_bus;
			rbd_pkg::FN_SHL:    res = {bus.r_bus[14:0], 1'b0};
			rbd_pkg::FN_SHR:    res = {1'b0, bus.r_bus[15:1]};
			rbd_pkg::FN_ROL:    res = {bus.r_bus[14:0], bus.r_bus[15]};
			rbd_pkg::FN_ROR:    res = {bus.r_bus[0], bus.r_bus[15:1]};
			rbd_pkg::FN_ROL_E:
			begin
				res  = {bus.r_bus[14:0], bus.e_in};              // extend links the pair
				cout = bus.r_bus[15];
			end
			rbd_pkg::FN_ROR_E:
			begin
				res  = {bus.e_in, bus.r_bus[15:1]};
				cout = bus.r_bus[0];
			end
			default:            res = bus.r_bus;
		endcase
	end

	assign bus.t_bus = res;
	assign bus.carry = cout;
	assign bus.zero  = (res == `RBD_ZERO_WORD);
	// like signs: positive overflows on a carry into bit 15, negative without one
	assign bus.ovf   = use_add & (r_neg == b_neg) &
		(r_neg ? ~c14 : c14);
endmodule : rbd_alu

/* File: hdl/rbd_datapath.sv */
// working registers and three-bus datapath: data, program counter, address, two accumulators
//
// Overview of operation
// - registers never copy straight into one another
// - every bus is sixteen parallel lines
// - two operand buses in, one result bus out
// - stores load data register first, then write
// - program counter advances by one
// - taken skip advances program counter by two
// - jump loads program counter from a register
// - halt stops sequential stepping
// - only address register drives memory address
// - fetch copies program counter into address register
// - program counter holds during multi-phase instructions
// - completion loads incremented count into both
// - accumulators add, compare, shift, test, complement
// - boolean ops only into first accumulator
// - carry out of bit 15 sets extend
// - clear-extend command; software clears before adds
// - extend links accumulators as double width
// - positive add overflows on carry into sign
// - negative add overflows without carry into sign
// - opposite signs never set overflow
// - add-memory puts data and accumulator on buses
// - accumulators answer reads and writes of memory locations zero, one; fetch goes to core
// - data register cleared at each core read start
// - address bits 14..12 pick the memory module
`timescale 1ns/10ps
`include "rbd_defines.svh"
module rbd_datapath (
	input  wire logic                [15:0] i_mem_rdata,
	input  wire logic                       i_clk,
	input  wire logic                       i_reset_n,
	input  wire logic                       i_op_valid,
	input  wire rbd_pkg::rbd_op_e           i_op,
	input  wire rbd_pkg::rbd_src_e          i_rsrc,
	input  wire rbd_pkg::rbd_src_e          i_ssrc,
	input  wire rbd_pkg::rbd_func_e         i_func,
	input  wire logic                 [4:0] i_dst,
	input  wire logic                       i_mem_valid,
	output logic                            o_ready,
	output logic                            o_mem_read,
	output logic                            o_mem_write,
	output logic                      [2:0] o_mem_module,
	output logic                     [14:0] o_mem_addr,
	output logic                     [15:0] o_mem_wdata,
	output logic                     [15:0] o_pc,
	output logic                     [15:0] o_acc_a,
	output logic                     [15:0] o_acc_b,
	output logic                            o_extend,
	output logic                            o_overflow,
	output logic                            o_zero,
	output logic                            o_halted
);
	typedef enum logic {ST_IDLE, ST_READ_WAIT} rbd_state_e;

	// working registers
	logic            [15:0] t_reg;
	logic            [15:0] p_reg;
	logic            [15:0] m_reg;
	logic            [15:0] a_reg;
	logic            [15:0] b_reg;
	logic                   e_reg;
	logic                   o_reg;
	logic                   zero_reg;
	logic                   halted;
	logic                   ready;
	logic                   mem_read;
	logic                   mem_write;
	logic             [2:0] mem_module;
	rbd_state_e             state;

	rbd_alu_if              alu_bus ();

	// operand source selection, used for both operand buses
	function automatic logic [15:0] src_value(input rbd_pkg::rbd_src_e sel,
		input logic [15:0] t, input logic [15:0] p, input logic [15:0] m,
		input logic [15:0] a, input logic [15:0] b);
		case (sel)
			rbd_pkg::SRC_T: return t;
			rbd_pkg::SRC_P: return p;
			rbd_pkg::SRC_M: return m;
			rbd_pkg::SRC_A: return a;
			rbd_pkg::SRC_B: return b;
			default:        return `RBD_ZERO_WORD;
		endcase
	endfunction : src_value

	// command decode; commands are only taken while idle
	wire logic take;
	wire logic op_micro;
	wire logic op_fetch;
	wire logic op_read;
	wire logic op_write;
	wire logic op_adv;
	wire logic op_skip;
	wire logic op_jump;
	wire logic acc_hit;
	wire logic core_read;
	wire logic core_write;
	wire logic stepping;

	assign take       = i_op_valid & ready;
	assign op_micro   = take & (i_op == rbd_pkg::OP_MICRO);
	assign op_fetch   = take & (i_op == rbd_pkg::OP_FETCH) & ~halted;
	assign op_read    = take & (i_op == rbd_pkg::OP_READ);
	assign op_write   = take & (i_op == rbd_pkg::OP_WRITE);
	assign op_adv     = take & (i_op == rbd_pkg::OP_ADVANCE) & ~halted;
	assign op_skip    = take & (i_op == rbd_pkg::OP_SKIP) & ~halted;
	assign op_jump    = take & (i_op == rbd_pkg::OP_JUMP);
	assign stepping   = op_adv | op_skip;
	// for read and write, locations zero and one are the accumulators, not core; fetch reads core
	assign acc_hit    = (m_reg[15:1] == 15'h0000);
	assign core_read  = op_fetch | (op_read & ~acc_hit);
	assign core_write = op_write & ~acc_hit;

	// left operand bus: every movement goes through the buses
	wire rbd_pkg::rbd_src_e r_sel;
	wire rbd_pkg::rbd_src_e s_sel;
	wire rbd_pkg::rbd_func_e func;
	wire rbd_pkg::rbd_src_e acc_src;

	assign acc_src = m_reg[0] ? rbd_pkg::SRC_B : rbd_pkg::SRC_A;
	assign r_sel   = op_micro ? i_rsrc :
		(op_fetch | stepping) ? rbd_pkg::SRC_P :
		op_jump ? i_rsrc :
		(op_read & acc_hit) ? acc_src :
		rbd_pkg::SRC_ZERO;
	// right operand bus: memory word for add-memory and accumulator stores
	assign s_sel   = op_micro ? i_ssrc :
		(op_write & acc_hit) ? rbd_pkg::SRC_T :
		rbd_pkg::SRC_ZERO;
	assign func    = op_micro ? i_func :
		op_adv ? rbd_pkg::FN_INC :
		op_skip ? rbd_pkg::FN_INC2 :
		(op_write & acc_hit) ? rbd_pkg::FN_PASS_S :
		rbd_pkg::FN_PASS_R;

	assign alu_bus.r_bus = src_value(r_sel, t_reg, p_reg, m_reg, a_reg, b_reg);
	assign alu_bus.s_bus = src_value(s_sel, t_reg, p_reg, m_reg, a_reg, b_reg);
	assign alu_bus.func  = func;
	assign alu_bus.e_in  = e_reg;

	rbd_alu u_alu (
		.bus (alu_bus.alu)
	);

	// store enables from the result bus
	wire logic [4:0] micro_dst;
	wire logic [4:0] dst;
	wire logic       logic_fn;
	wire logic       acc_dst;
	wire logic       e_fn;
	wire logic       rot_e_fn;

	assign logic_fn  = rbd_pkg::rbd_is_logic(func);
	// the program counter is never a plain destination, only stepped or jumped;
	// boolean results are kept out of the second accumulator
	assign micro_dst = i_dst & ~(5'h01 << `RBD_DST_P) &
		~({logic_fn, 4'h0});
	assign dst = op_micro ? micro_dst :
		op_fetch ? (5'h01 << `RBD_DST_M) :
		stepping ? ((5'h01 << `RBD_DST_P) | (5'h01 << `RBD_DST_M)) :
		op_jump ? (5'h01 << `RBD_DST_P) :
		(op_read & acc_hit) ? (5'h01 << `RBD_DST_T) :
		(op_write & acc_hit) ? (m_reg[0] ? (5'h01 << `RBD_DST_B) :
			(5'h01 << `RBD_DST_A)) :
		`RBD_DST_NONE;
	assign acc_dst  = dst[`RBD_DST_A] | dst[`RBD_DST_B];
	assign e_fn     = (func == rbd_pkg::FN_ADD) & acc_dst;
	assign rot_e_fn = ((func == rbd_pkg::FN_ROL_E) | (func == rbd_pkg::FN_ROR_E)) & acc_dst;

	// next values of the working registers
	wire logic [15:0] next_m;
	wire logic        clear_e;
	wire logic        clear_o;
	wire logic        set_o;

	assign next_m  = dst[`RBD_DST_M] ? alu_bus.t_bus : m_reg;
	assign clear_e = take & (i_op == rbd_pkg::OP_CLEAR_E);
	assign clear_o = take & (i_op == rbd_pkg::OP_CLEAR_O);
	assign set_o   = (func == rbd_pkg::FN_ADD) & acc_dst & alu_bus.ovf;

	// data register: cleared as a core read starts, then loaded by the sense data
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			t_reg <= `RBD_RESET_WORD;
		else if (core_read)
			t_reg <= `RBD_ZERO_WORD;
		else if ((state == ST_READ_WAIT) && i_mem_valid)
			t_reg <= i_mem_rdata;
		else if (dst[`RBD_DST_T])
			t_reg <= alu_bus.t_bus;
	end

	// program counter moves only by step, skip or jump
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			p_reg <= `RBD_RESET_WORD;
		else if (dst[`RBD_DST_P])
			p_reg <= alu_bus.t_bus;
	end

	// address register, the only source of the core address
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			m_reg <= `RBD_RESET_WORD;
		else
			m_reg <= next_m;
	end

	// accumulators
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			a_reg <= `RBD_RESET_WORD;
			b_reg <= `RBD_RESET_WORD;
		end
		else
		begin
			if (dst[`RBD_DST_A])
				a_reg <= alu_bus.t_bus;
			if (dst[`RBD_DST_B])
				b_reg <= alu_bus.t_bus;
		end
	end

	// extend: a carry sets it and a rotate through it reloads it; a clear
	// and a carry cannot meet, since both need a command in the same cycle
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			e_reg <= 1'b0;
		else if (rot_e_fn)
			e_reg <= alu_bus.carry;
		else if (e_fn && alu_bus.carry)
			e_reg <= 1'b1;
		else if (clear_e)
			e_reg <= 1'b0;
	end

	// overflow: sticky, opposite-sign adds never reach set_o
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_reg <= 1'b0;
		else if (set_o)
			o_reg <= 1'b1;
		else if (clear_o)
			o_reg <= 1'b0;
	end

	// test flag: zero result of the last micro step, equality after a compare
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			zero_reg <= 1'b0;
		else if (op_micro)
			zero_reg <= alu_bus.zero;
	end

	// halt latch: freezes fetch and stepping, a jump or run still acts
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			halted <= 1'b0;
		else if (take && (i_op == rbd_pkg::OP_HALT))
			halted <= 1'b1;
		else if (take && (i_op == rbd_pkg::OP_RUN))
			halted <= 1'b0;
	end

	// core read handshake; the sequencer is held off until the word arrives
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			state <= ST_IDLE;
		else
			case (state)
				ST_IDLE:      state <= core_read ? ST_READ_WAIT : ST_IDLE;
				ST_READ_WAIT: state <= i_mem_valid ? ST_IDLE : ST_READ_WAIT;
				default:      state <= ST_IDLE;
			endcase
	end

	// registered memory strobes; module select follows the new address
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			mem_read   <= 1'b0;
			mem_write  <= 1'b0;
			mem_module <= 3'h0;
			ready      <= 1'b0;
		end
		else
		begin
			mem_read   <= core_read;
			mem_write  <= core_write;
			mem_module <= next_m[`RBD_MOD_HI:`RBD_MOD_LO];
			ready      <= ~core_read & ((state == ST_IDLE) |
				((state == ST_READ_WAIT) & i_mem_valid));
		end
	end

	assign o_ready      = ready;
	assign o_mem_read   = mem_read;
	assign o_mem_write  = mem_write;
	assign o_mem_module = mem_module;
	assign o_mem_addr   = m_reg[`RBD_ADDR_MSB:0];
	assign o_mem_wdata  = t_reg;
	assign o_pc         = p_reg;
	assign o_acc_a      = a_reg;
	assign o_acc_b      = b_reg;
	assign o_extend     = e_reg;
	assign o_overflow   = o_reg;
	assign o_zero       = zero_reg;
	assign o_halted     = halted;
endmodule : rbd_datapath

/* File: dv/rbd_datapath_asserts.sv */
// concurrent checks on the datapath top ports
`timescale 1ns/10ps
module rbd_datapath_asserts (
	input  wire logic                i_clk,
	input  wire logic                i_reset_n,
	input  wire logic                i_op_valid,
	input  wire rbd_pkg::rbd_op_e    i_op,
	input  wire rbd_pkg::rbd_func_e  i_func,
	input  wire logic                o_ready,
	input  wire logic                o_mem_read,
	input  wire logic                o_mem_write,
	input  wire logic          [2:0] o_mem_module,
	input  wire logic         [14:0] o_mem_addr,
	input  wire logic         [15:0] o_mem_wdata,
	input  wire logic         [15:0] o_pc,
	input  wire logic                o_extend,
	input  wire logic                o_halted
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	// a command counts only when offered while ready
	wire logic        take;
	wire logic [14:0] pc_low;
	assign take   = i_op_valid && o_ready;
	assign pc_low = o_pc[14:0];

	a_read_clears: assert property (o_mem_read |-> o_mem_wdata == 16'h0000 && !o_ready)
		else $error("data register not cleared at read start");
	// back-to-back writes are legal, so each strobe cycle must trace to its own command
	a_write_pulse: assert property (o_mem_write
		|-> $past(take) && $past(i_op) == rbd_pkg::OP_WRITE)
		else $error("write strobe without a write command");
	a_module_pick: assert property ((o_mem_read || o_mem_write) |-> o_mem_module == o_mem_addr[14:12])
		else $error("module select differs from address bits");
	a_fetch_addr: assert property (take && i_op == rbd_pkg::OP_FETCH && !o_halted && o_pc > 16'h0001
		|=> o_mem_read && o_mem_addr == $past(pc_low))
		else $error("fetch did not address the program count");
	a_advance_one: assert property (take && i_op == rbd_pkg::OP_ADVANCE && !o_halted
		|=> o_pc == $past(o_pc) + 16'h0001 && o_mem_addr == pc_low)
		else $error("advance did not step by one into both");
	a_skip_two: assert property (take && i_op == rbd_pkg::OP_SKIP && !o_halted
		|=> o_pc == $past(o_pc) + 16'h0002 && o_mem_addr == pc_low)
		else $error("skip did not step by two");
	a_halt_hold: assert property (take && i_op == rbd_pkg::OP_ADVANCE && o_halted |=> $stable(o_pc))
		else $error("program count moved while halted");
	a_pc_kept: assert property (take && (i_op == rbd_pkg::OP_MICRO || i_op == rbd_pkg::OP_READ
		|| i_op == rbd_pkg::OP_WRITE) |=> $stable(o_pc))
		else $error("program count changed mid instruction");
	// a rotate through extend is the one carry event that may lower it
	a_extend_sticky: assert property ($fell(o_extend) |-> $past(take) &&
		($past(i_op) == rbd_pkg::OP_CLEAR_E || ($past(i_op) == rbd_pkg::OP_MICRO &&
		($past(i_func) == rbd_pkg::FN_ROL_E || $past(i_func) == rbd_pkg::FN_ROR_E))))
		else $error("extend dropped without a clear or rotate");
endmodule : rbd_datapath_asserts

/* File: dv/rbd_core_model.sv */
// behavioural core memory on the far side of the datapath
`timescale 1ns/10ps
module rbd_core_model (
	input  wire logic        i_clk,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic  [2:0] i_module,
	input  wire logic [14:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic  [3:0] i_lat,
	output logic      [15:0] o_rdata,
	output logic             o_valid
);
	logic [15:0] mem [0:255];
	logic  [3:0] cnt;
	logic  [7:0] rd_idx;
	wire   [7:0] idx;
	// module bits pick the bank; five low bits are all the bench needs
	assign idx = {i_module, i_addr[4:0]};

	initial
	begin
		o_rdata = 16'h0000;
		o_valid = 1'b0;
		cnt     = 4'h0;
		rd_idx  = 8'h00;
	end

	// answer a read after i_lat cycles; idle data lines toggle so stale values never match
	always @(posedge i_clk)
	begin
		o_valid <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_read && i_lat == 4'h1)
		begin
			o_valid <= 1'b1;
			o_rdata <= mem[idx];
		end
		else if (i_read)
		begin
			cnt    <= i_lat - 4'h1;
			rd_idx <= idx;
		end
		else if (cnt == 4'h1)
		begin
			cnt     <= 4'h0;
			o_valid <= 1'b1;
			o_rdata <= mem[rd_idx];
		end
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		if (i_write)
			mem[idx] <= i_wdata;
	end
endmodule : rbd_core_model

/* File: dv/rbd_datapath_tb.sv */
// self-checking bench for the register bus datapath
`timescale 1ns/10ps
module rbd_datapath_tb;
	logic               i_clk, i_reset_n, i_op_valid;
	rbd_pkg::rbd_op_e   i_op;
	rbd_pkg::rbd_src_e  i_rsrc, i_ssrc;
	rbd_pkg::rbd_func_e i_func;
	logic         [4:0] i_dst;
	logic         [3:0] lat;
	logic        [15:0] rdata, o_mem_wdata, o_pc, o_acc_a, o_acc_b, pc_exp, acc;
	logic               mvalid, o_ready, o_mem_read, o_mem_write;
	logic               o_extend, o_overflow, o_zero, o_halted;
	logic         [2:0] o_mem_module;
	logic        [14:0] o_mem_addr;
	logic        [15:0] img [0:15];
	int                 n_errors, check_count;

	rbd_datapath dut (.i_mem_rdata(rdata), .i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_op_valid(i_op_valid), .i_op(i_op), .i_rsrc(i_rsrc), .i_ssrc(i_ssrc),
		.i_func(i_func), .i_dst(i_dst), .i_mem_valid(mvalid), .o_ready(o_ready),
		.o_mem_read(o_mem_read), .o_mem_write(o_mem_write), .o_mem_module(o_mem_module),
		.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_pc(o_pc), .o_acc_a(o_acc_a),
		.o_acc_b(o_acc_b), .o_extend(o_extend), .o_overflow(o_overflow), .o_zero(o_zero),
		.o_halted(o_halted));

	rbd_core_model core (.i_clk(i_clk), .i_read(o_mem_read), .i_write(o_mem_write),
		.i_module(o_mem_module), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_lat(lat),
		.o_rdata(rdata), .o_valid(mvalid));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// bounded wait; a core read holds ready low until its data lands;
	// at least one edge passes so the strobe never drops and rises in one step
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		while (o_ready !== 1'b1 && n < 200);
		chk(o_ready, 16'h0001);
	endtask : wait_rdy

	task automatic cmd(input rbd_pkg::rbd_op_e op,
		input rbd_pkg::rbd_src_e r = rbd_pkg::SRC_ZERO,
		input rbd_pkg::rbd_src_e s = rbd_pkg::SRC_ZERO,
		input rbd_pkg::rbd_func_e f = rbd_pkg::FN_PASS_R, input logic [4:0] d = 5'h00);
		wait_rdy();
		i_op_valid = 1'b1;
		i_op       = op;
		i_rsrc     = r;
		i_ssrc     = s;
		i_func     = f;
		i_dst      = d;
		@(posedge i_clk);
		#1;
		i_op_valid = 1'b0;
	endtask : cmd

	// fetch the word at the program count into the data register, then step on
	task automatic fetch(input logic [15:0] exp);
		cmd(rbd_pkg::OP_FETCH);
		chk(o_mem_read, 16'h0001);
		chk(o_mem_addr, pc_exp[14:0]);
		chk(o_mem_wdata, 16'h0000);
		wait_rdy();
		chk(o_mem_wdata, exp);
		cmd(rbd_pkg::OP_ADVANCE);
		pc_exp = pc_exp + 16'h0001;
		chk(o_pc, pc_exp);
		chk(o_mem_addr, pc_exp[14:0]);
	endtask : fetch

	task automatic t_step;
		chk(o_pc, 16'h0000);
		cmd(rbd_pkg::OP_ADVANCE);
		cmd(rbd_pkg::OP_ADVANCE);
		cmd(rbd_pkg::OP_SKIP);
		pc_exp = 16'h0004;
		chk(o_pc, pc_exp);
		chk(o_mem_addr, pc_exp[14:0]);
		$display("test step done");
	endtask : t_step

	// each of the four loop sums starts from cleared flags; the third and fourth carry out
	task automatic t_add;
		logic [15:0] a, b;
		logic [16:0] sum;
		for (int k = 0; k < 4; k++)
		begin
			lat = 4'(k + 1);
			a   = img[4 + 2 * k];
			b   = img[5 + 2 * k];
			sum = {1'b0, a} + {1'b0, b};
			fetch(a);
			cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_T, rbd_pkg::SRC_ZERO, rbd_pkg::FN_PASS_R, 5'h08);
			chk(o_acc_a, a);
			fetch(b);
			cmd(rbd_pkg::OP_CLEAR_E);
			cmd(rbd_pkg::OP_CLEAR_O);
			cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_A, rbd_pkg::SRC_T, rbd_pkg::FN_ADD, 5'h08);
			chk(o_acc_a, sum[15:0]);
			chk(o_extend, 16'(sum[16]));
			chk(o_overflow, 16'((a[15] == b[15]) && (sum[15] != a[15])));
		end
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_A, rbd_pkg::SRC_T, rbd_pkg::FN_ADD, 5'h10);
		chk(o_acc_b, 16'h0001);
		chk(o_extend, 16'h0001);
		cmd(rbd_pkg::OP_CLEAR_E);
		chk(o_extend, 16'h0000);
		$display("test add done");
	endtask : t_add

	// boolean results land in the first accumulator even when the second is asked for
	task automatic t_logic;
		rbd_pkg::rbd_func_e f;
		acc = img[12];
		fetch(acc);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_T, rbd_pkg::SRC_ZERO, rbd_pkg::FN_PASS_R, 5'h08);
		fetch(img[13]);
		for (int k = 0; k < 3; k++)
		begin
			f   = (k == 0) ? rbd_pkg::FN_AND : (k == 1) ? rbd_pkg::FN_XOR : rbd_pkg::FN_OR;
			acc = (k == 0) ? (acc & img[13]) : (k == 1) ? (acc ^ img[13]) : (acc | img[13]);
			cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_A, rbd_pkg::SRC_T, f, 5'h18);
			chk(o_acc_a, acc);
			chk(o_acc_b, 16'h0001);
		end
		$display("test logic done");
	endtask : t_logic

	task automatic t_store;
		fetch(img[14]);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_T, rbd_pkg::SRC_ZERO, rbd_pkg::FN_PASS_R, 5'h04);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_A, rbd_pkg::SRC_ZERO, rbd_pkg::FN_PASS_R, 5'h01);
		cmd(rbd_pkg::OP_WRITE);
		chk(o_mem_write, 16'h0001);
		chk(o_mem_wdata, acc);
		chk(o_mem_module, 16'h0003);
		@(posedge i_clk);
		#1;
		chk(core.mem[8'h65], acc);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_B, rbd_pkg::SRC_ZERO, rbd_pkg::FN_PASS_R, 5'h04);
		cmd(rbd_pkg::OP_READ);
		chk(o_mem_read, 16'h0000);
		wait_rdy();
		chk(o_mem_wdata, 16'h0001);
		$display("test store done");
	endtask : t_store

	task automatic t_halt;
		cmd(rbd_pkg::OP_HALT);
		chk(o_halted, 16'h0001);
		cmd(rbd_pkg::OP_ADVANCE);
		chk(o_pc, pc_exp);
		cmd(rbd_pkg::OP_RUN);
		cmd(rbd_pkg::OP_JUMP, rbd_pkg::SRC_T);
		chk(o_pc, 16'h0001);
		chk(o_mem_addr, 16'h0001);
		$display("test halt done");
	endtask : t_halt

	// a 32-bit rotate through extend, first accumulator low, then back; compares set the flag
	task automatic t_shift;
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_A, rbd_pkg::SRC_ZERO, rbd_pkg::FN_CMPL, 5'h08);
		chk(o_acc_a, 16'hC3C3);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_A, rbd_pkg::SRC_ZERO, rbd_pkg::FN_ROL_E, 5'h08);
		chk(o_acc_a, 16'h8786);
		chk(o_extend, 16'h0001);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_B, rbd_pkg::SRC_ZERO, rbd_pkg::FN_ROL_E, 5'h10);
		chk(o_acc_b, 16'h0003);
		chk(o_extend, 16'h0000);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_B, rbd_pkg::SRC_ZERO, rbd_pkg::FN_ROR_E, 5'h10);
		chk(o_extend, 16'h0001);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_A, rbd_pkg::SRC_ZERO, rbd_pkg::FN_ROR_E, 5'h08);
		chk(o_acc_a, 16'hC3C3);
		chk(o_acc_b, 16'h0001);
		chk(o_extend, 16'h0000);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_B, rbd_pkg::SRC_T, rbd_pkg::FN_CMP, 5'h00);
		chk(o_zero, 16'h0001);
		cmd(rbd_pkg::OP_MICRO, rbd_pkg::SRC_A, rbd_pkg::SRC_T, rbd_pkg::FN_CMP, 5'h00);
		chk(o_zero, 16'h0000);
		$display("test shift done");
	endtask : t_shift

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	initial
	begin
		#200000;
		n_errors++;
		give_verdict();
	end

	initial
	begin
		img = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1234, 16'h5678, 16'h7FFF,
			16'h0001, 16'h8000, 16'h8000, 16'hFFFF, 16'h0001, 16'hF0F0, 16'h3C3C,
			16'h3005, 16'h0000};
		for (int k = 0; k < 16; k++)
			core.mem[k] = img[k];
		{n_errors, check_count} = '0;
		{i_reset_n, i_op_valid, i_dst, pc_exp, acc} = '0;
		i_op   = rbd_pkg::OP_MICRO;
		i_rsrc = rbd_pkg::SRC_ZERO;
		i_ssrc = rbd_pkg::SRC_ZERO;
		i_func = rbd_pkg::FN_PASS_R;
		lat = 4'h1;
		repeat (20) @(posedge i_clk);
		#1;
		i_reset_n = 1'b1;
		t_step();
		t_add();
		t_logic();
		t_store();
		t_halt();
		t_shift();
		give_verdict();
	end
endmodule : rbd_datapath_tb

bind rbd_datapath rbd_datapath_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_op_valid(i_op_valid), .i_op(i_op), .i_func(i_func), .o_ready(o_ready),
	.o_mem_read(o_mem_read),
	.o_mem_write(o_mem_write), .o_mem_module(o_mem_module), .o_mem_addr(o_mem_addr),
	.o_mem_wdata(o_mem_wdata), .o_pc(o_pc), .o_extend(o_extend), .o_halted(o_halted));
